/* File: src/epa_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 10 MHz system clock.
// Notes:   Included by every design module of the emulated PHY; the package does not include it.
`ifndef EPA_DEFS_SVH
`define EPA_DEFS_SVH
// ------------------------------------------------------------
// Emulated PHY register numbers
// ------------------------------------------------------------
`define EPA_R_BC      5'h00
`define EPA_R_BS      5'h01
`define EPA_R_ID1     5'h02
`define EPA_R_ID2     5'h03
`define EPA_R_ADV     5'h04
`define EPA_R_LP      5'h05
`define EPA_R_EXP     5'h06
`define EPA_PHYAD     5'h00
// Identity words: values arbitrary
`define EPA_ID1_VAL   16'h0A5A
`define EPA_ID2_VAL   16'h5C30
// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define EPA_BC_RST    15
`define EPA_BC_SPD    13
`define EPA_BC_ANEN   12
`define EPA_BC_RESTART 9
`define EPA_BC_DUP    8
`define EPA_BC_RESET  16'h3100
`define EPA_BC_WMASK  16'h7D80
`define EPA_BS_FIXED  16'h780D
`define EPA_BS_ANC    5
`define EPA_ADV_RESET 16'h0DE1
`define EPA_ADV_WMASK 16'h0DE0
`define EPA_SEL_8023  5'h01
`define EPA_TECH_PD   4'h4
`define EPA_RC_PHY    3
`define EPA_RC_DIG    10
`define EPA_PMT_PHY   10
`define EPA_FC_SEL    0
`define EPA_FC_TX     1
`define EPA_FC_RX     2
`define EPA_MD_PRE    6'h20
`define EPA_MD_HDR    6'h0C
`define EPA_MD_LAST   6'h0F
// ------------------------------------------------------------
// Bus register map (byte addresses) and index codes
// ------------------------------------------------------------
`define EPA_A_RSTCTL  8'h00
`define EPA_A_PMT     8'h04
`define EPA_A_FC      8'h08
`define EPA_A_RELOAD  8'h0C
`define EPA_A_STATUS  8'h10
`define EPA_I_RSTCTL  3'h0
`define EPA_I_PMT     3'h1
`define EPA_I_FC      3'h2
`define EPA_I_RELOAD  3'h3
`define EPA_I_STATUS  3'h4
`define EPA_I_NONE    3'h7
`define EPA_RESP_OK   2'h0
`define EPA_RESP_ERR  2'h2
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define EPA_CLK_NS     100
`define EPA_SELFCLR_NS 102000
`define EPA_LONG_CYC   11'(`EPA_SELFCLR_NS / `EPA_CLK_NS)
`define EPA_SHORT_CYC  11'h004
`endif

/* File: src/epa_mdio_slave.sv */
// Purpose: Clause 22 management frame slave.
// Assumes: MDC well below the system clock rate.
// Notes:   Pins pass three flops; a change counts once two agree.
`include "epa_defs.svh"
module epa_mdio_slave
	import epa_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Management pins
	input  wire logic        mdc_in,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_out,
	// Register side
	input  wire logic [15:0] rdata_in,
	output epa_mreq_t        req_out
);
	logic [2:0]  mdc_s_q;
	logic [2:0]  mdio_s_q;
	logic        mdc_v_q;
	logic        mdio_v_q;
	logic        mdc_p_q;
	epa_md_t     st_q;
	logic [5:0]  cnt_q;
	logic [15:0] sh_q;
	logic        rd_q;
	logic        rise;
	logic [12:0] hdr;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mdc_s_q  <= 3'h0;
			mdio_s_q <= 3'h7;
			mdc_v_q  <= 1'b0;
			mdio_v_q <= 1'b1;
			mdc_p_q  <= 1'b0;
		end else begin
			mdc_s_q  <= {mdc_s_q[1:0], mdc_in};
			mdio_s_q <= {mdio_s_q[1:0], mdio_in};
			if (mdc_s_q[1] == mdc_s_q[2]) begin
				mdc_v_q <= mdc_s_q[2];
			end
			if (mdio_s_q[1] == mdio_s_q[2]) begin
				mdio_v_q <= mdio_s_q[2];
			end
			mdc_p_q <= mdc_v_q;
		end
	end

	assign rise = mdc_v_q & ~mdc_p_q;
	assign hdr  = {sh_q[11:0], mdio_v_q};

	// ------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			st_q        <= MD_PRE;
			cnt_q       <= 6'h00;
			sh_q        <= 16'h0000;
			rd_q        <= 1'b0;
			mdio_out    <= 1'b0;
			mdio_oe_out <= 1'b0;
			req_out     <= '0;
		end else begin
			req_out.wr <= 1'b0;
			if (rise) begin
				case (st_q)
				MD_PRE: begin
					if (mdio_v_q) begin
						if (cnt_q != `EPA_MD_PRE) begin
							cnt_q <= cnt_q + 6'h01;
						end
					end else if (cnt_q == `EPA_MD_PRE) begin
						st_q  <= MD_HDR;
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= 6'h00;
					end
				end
				MD_HDR: begin
					sh_q  <= {sh_q[14:0], mdio_v_q};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == `EPA_MD_HDR) begin
						cnt_q <= 6'h00;
						req_out.addr <= hdr[4:0];
						rd_q  <= hdr[11:10] == 2'b10;
						if (hdr[12] && hdr[9:5] == `EPA_PHYAD && hdr[11] != hdr[10]) begin
							st_q <= MD_TA;
						end else begin
							st_q <= MD_PRE;
						end
					end
				end
				MD_TA: begin
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == 6'h00) begin
						mdio_oe_out <= rd_q;
						mdio_out    <= 1'b0;
					end else begin
						st_q     <= MD_DATA;
						cnt_q    <= 6'h00;
						mdio_out <= rdata_in[15];
						sh_q     <= {rdata_in[14:0], 1'b0};
					end
				end
				MD_DATA: begin
					cnt_q <= cnt_q + 6'h01;
					if (rd_q) begin
						mdio_out <= sh_q[15];
						sh_q     <= {sh_q[14:0], 1'b0};
					end else begin
						sh_q <= {sh_q[14:0], mdio_v_q};
					end
					if (cnt_q == `EPA_MD_LAST) begin
						st_q        <= MD_PRE;
						cnt_q       <= 6'h00;
						mdio_oe_out <= 1'b0;
						req_out.wr  <= ~rd_q;
						req_out.wdata <= {sh_q[14:0], mdio_v_q};
					end
				end
				default: begin
					st_q <= MD_PRE;
				end
				endcase
			end
		end
	end
endmodule : epa_mdio_slave

/* File: src/epa_pkg.sv */
// Purpose: Types shared by the emulated PHY modules.
// Assumes: Nothing.
// Notes:   Constants live in epa_defs.svh.
package epa_pkg;
	typedef enum {AN_IDLE, AN_CPLT, AN_PAGE, AN_LATCH} epa_an_t;
	typedef enum {MD_PRE, MD_HDR, MD_TA, MD_DATA} epa_md_t;
	typedef struct packed {
		logic speed100;
		logic full;
		logic tx_pause;
		logic rx_pause;
	} epa_link_t;
	typedef struct packed {
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} epa_mreq_t;
endpackage : epa_pkg

/* File: src/epa_resolve.sv */
// Purpose: Highest common mode against the fixed emulated partner.
// Assumes: Partner offers all four modes.
// Notes:   Purely combinational.
`include "epa_defs.svh"
module epa_resolve
	import epa_pkg::*;
(
	// Local technology bits: 3=100F 2=100H 1=10F 0=10H
	input  wire logic [3:0] adv_in,
	// Result
	output logic            common_out,
	output logic            speed_out,
	output logic            full_out,
	output logic [3:0]      tech_out
);
	logic [3:0] both;
	always_comb begin
		both       = adv_in & 4'hF; // RULE5 RULE8
		common_out = |both;
		tech_out   = common_out ? 4'hF : `EPA_TECH_PD; // RULE9 RULE10
		if (both[3]) begin // RULE5
			speed_out = 1'b1;
			full_out  = 1'b1;
		end else if (both[2]) begin
			speed_out = 1'b1;
			full_out  = 1'b0;
		end else if (both[1]) begin
			speed_out = 1'b0;
			full_out  = 1'b1;
		end else if (both[0]) begin
			speed_out = 1'b0;
			full_out  = 1'b0;
		end else begin
			speed_out = 1'b1; // RULE10
			full_out  = 1'b0;
		end
	end
endmodule : epa_resolve

/* File: src/epa_top.sv */
// Purpose: Emulated single-port PHY with emulated auto-negotiation.
// Assumes: Host MAC manages it over MDIO; software over AXI4-Lite.
// Notes:   The switch fabric is the fixed emulated link partner.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`include "epa_defs.svh"
// Contract
// [RULE1] Full clause 22 register bank over MDIO; the code has registers 0 to 6 only, others read 16'hFFFF
// [RULE2] Negotiation only while enable bit 12 set
// [RULE3] Resets, bit 9 and reload restart negotiation
// [RULE4] Complete, then page received, then latch result
// [RULE5] AND abilities, pick highest common mode
// [RULE6] Four ability bits set after reset, writable
// [RULE7] Later advertisement writes wait for renegotiation
// [RULE8] Partner offers all four; no extras
// [RULE9] Common mode: partner-able set, partner abilities shown
// [RULE10] No common mode: 100 half, one bit
// [RULE11] Disabled negotiation forces speed and duplex
// [RULE12] Host ignores forced bits while negotiating
// [RULE13] Pause advertised from bits 10 and 11
// [RULE14] Partner pause mirrors local pause bits
// [RULE15] Manual flow control when disabled or selected
// [RULE16] Manual flow writes leave advertisement alone
// [RULE17] Reset control bit 3 self-clears after 102us
// [RULE18] Control bit 15 resets, reads zero after
// [RULE19] Power control bit 10 self-clears after 102us
// [RULE20] Drive resolved or forced settings to fabric
module epa_top
	import epa_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        hardware_reset_pin_n_in,
	// Management pins
	input  wire logic        mdc_in,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_out,
	// AXI4-Lite write
	input  wire logic [7:0]  s_awaddr_in,
	input  wire logic        s_awvalid_in,
	output logic             s_awready_out,
	input  wire logic [31:0] s_wdata_in,
	input  wire logic [3:0]  s_wstrb_in,
	input  wire logic        s_wvalid_in,
	output logic             s_wready_out,
	output logic [1:0]       s_bresp_out,
	output logic             s_bvalid_out,
	input  wire logic        s_bready_in,
	// AXI4-Lite read
	input  wire logic [7:0]  s_araddr_in,
	input  wire logic        s_arvalid_in,
	output logic             s_arready_out,
	output logic [31:0]      s_rdata_out,
	output logic [1:0]       s_rresp_out,
	output logic             s_rvalid_out,
	input  wire logic        s_rready_in,
	// Host-side fabric port
	output epa_link_t        host_link_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	function automatic logic [2:0] epa_idx(input logic [7:0] a);
		case (a)
		`EPA_A_RSTCTL: epa_idx = `EPA_I_RSTCTL;
		`EPA_A_PMT:    epa_idx = `EPA_I_PMT;
		`EPA_A_FC:     epa_idx = `EPA_I_FC;
		`EPA_A_RELOAD: epa_idx = `EPA_I_RELOAD;
		`EPA_A_STATUS: epa_idx = `EPA_I_STATUS;
		default:       epa_idx = `EPA_I_NONE;
		endcase
	endfunction : epa_idx

	logic [2:0]  hw_s_q;
	logic        hw_lvl_q;
	logic [7:0]  aw_addr_q;
	logic [15:0] wdat_q;
	logic [1:0]  wstrb_q;
	logic [15:0] wv;
	logic        wr_go;
	logic [2:0]  wsel;
	logic [10:0] rst_cnt_q;
	logic        rc_phy_q, pmt_phy_q, dig_q, bc_rst_q;
	logic        long_ld, short_ld, rst_end, busy;
	logic        set_rc, set_pmt, set_dig, set_rld, mbc;
	logic [15:0] bc_q, adv_q, lp_q, mrd;
	logic [2:0]  fc_q;
	epa_an_t     an_st;
	logic        an_req_q, an_take, an_set;
	logic        anc_q, page_q, lpa_q, res_spd_q, res_full_q, res_tx_q, res_rx_q;
	logic        r_common, r_spd, r_full;
	logic [3:0]  r_tech;
	logic [15:0] ard;
	epa_mreq_t   mreq;

	// ------------------------------------------------------------
	// Hardware reset pin
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			hw_s_q   <= 3'h7;
			hw_lvl_q <= 1'b1;
		end else begin
			hw_s_q <= {hw_s_q[1:0], hardware_reset_pin_n_in};
			if (hw_s_q[1] == hw_s_q[2]) begin
				hw_lvl_q <= hw_s_q[2];
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign wr_go = ~s_awready_out & ~s_wready_out & ~s_bvalid_out;
	assign wsel  = epa_idx(aw_addr_q);
	assign wv    = {wstrb_q[1] ? wdat_q[15:8] : 8'h00, wstrb_q[0] ? wdat_q[7:0] : 8'h00};

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s_awready_out <= 1'b1;
			s_wready_out  <= 1'b1;
			s_bvalid_out  <= 1'b0;
			s_bresp_out   <= `EPA_RESP_OK;
			aw_addr_q     <= 8'h00;
			wdat_q        <= 16'h0000;
			wstrb_q       <= 2'h0;
		end else begin
			if (s_awvalid_in && s_awready_out) begin
				aw_addr_q     <= s_awaddr_in;
				s_awready_out <= 1'b0;
			end
			if (s_wvalid_in && s_wready_out) begin
				wdat_q       <= s_wdata_in[15:0];
				wstrb_q      <= s_wstrb_in[1:0];
				s_wready_out <= 1'b0;
			end
			if (wr_go) begin
				s_bvalid_out <= 1'b1;
				s_bresp_out  <= wsel == `EPA_I_NONE ? `EPA_RESP_ERR : `EPA_RESP_OK;
			end
			if (s_bvalid_out && s_bready_in) begin
				s_bvalid_out  <= 1'b0;
				s_awready_out <= 1'b1;
				s_wready_out  <= 1'b1;
			end
		end
	end

	always_comb begin
		case (epa_idx(s_araddr_in))
		`EPA_I_RSTCTL: ard = 16'(dig_q) << `EPA_RC_DIG | 16'(rc_phy_q) << `EPA_RC_PHY;
		`EPA_I_PMT:    ard = 16'(pmt_phy_q) << `EPA_PMT_PHY;
		`EPA_I_FC:     ard = {10'h000, host_link_out.full, host_link_out.rx_pause,
		                      host_link_out.tx_pause, fc_q}; // RULE15
		`EPA_I_STATUS: ard = {10'h000, anc_q, lpa_q, host_link_out};
		default:       ard = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s_arready_out <= 1'b1;
			s_rvalid_out  <= 1'b0;
			s_rdata_out   <= 32'h0000_0000;
			s_rresp_out   <= `EPA_RESP_OK;
		end else if (s_arvalid_in && s_arready_out) begin
			s_arready_out <= 1'b0;
			s_rvalid_out  <= 1'b1;
			s_rdata_out   <= {16'h0000, ard};
			s_rresp_out   <= epa_idx(s_araddr_in) == `EPA_I_NONE ? `EPA_RESP_ERR : `EPA_RESP_OK;
		end else if (s_rvalid_out && s_rready_in) begin
			s_rvalid_out  <= 1'b0;
			s_arready_out <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Resets of the emulated PHY
	// ------------------------------------------------------------
	assign set_rc   = wr_go && wsel == `EPA_I_RSTCTL && wv[`EPA_RC_PHY];
	assign set_dig  = wr_go && wsel == `EPA_I_RSTCTL && wv[`EPA_RC_DIG];
	assign set_pmt  = wr_go && wsel == `EPA_I_PMT && wv[`EPA_PMT_PHY];
	assign set_rld  = wr_go && wsel == `EPA_I_RELOAD && wv[0];
	assign mbc      = mreq.wr && mreq.addr == `EPA_R_BC;
	assign long_ld  = set_rc | set_pmt;
	assign short_ld = ~hw_lvl_q | (mbc & mreq.wdata[`EPA_BC_RST]) | set_dig | set_rld;
	assign rst_end  = rst_cnt_q == 11'h001 && !long_ld && !short_ld;
	assign busy     = rst_cnt_q != 11'h000;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rst_cnt_q <= 11'h000;
			rc_phy_q  <= 1'b0;
			pmt_phy_q <= 1'b0;
			dig_q     <= 1'b0;
			bc_rst_q  <= 1'b0;
		end else begin
			if (long_ld) begin
				rst_cnt_q <= `EPA_LONG_CYC; // RULE17 RULE19
			end else if (short_ld && rst_cnt_q < `EPA_SHORT_CYC) begin
				rst_cnt_q <= `EPA_SHORT_CYC;
			end else if (busy) begin
				rst_cnt_q <= rst_cnt_q - 11'h001;
			end
			rc_phy_q  <= set_rc | (rc_phy_q & ~rst_end); // RULE17
			pmt_phy_q <= set_pmt | (pmt_phy_q & ~rst_end); // RULE19
			dig_q     <= set_dig | (dig_q & ~rst_end);
			bc_rst_q  <= (mbc & mreq.wdata[`EPA_BC_RST]) | (bc_rst_q & ~rst_end); // RULE18
		end
	end

	a_selfclr_load: assert property ($rose(rc_phy_q) |-> rst_cnt_q == `EPA_LONG_CYC) // RULE17
		else $error("reset control bit did not load the 102us count");
	a_selfclr_end: assert property ($fell(pmt_phy_q) |-> $past(rst_cnt_q) == 11'h001) // RULE19
		else $error("power control reset bit cleared early");
	a_bc_rst_done: assert property ($fell(bc_rst_q) |-> !busy && an_req_q) // RULE18
		else $error("basic control reset bit cleared before reset end");

	// ------------------------------------------------------------
	// Emulated PHY registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || busy) begin
			bc_q  <= `EPA_BC_RESET;
			adv_q <= `EPA_ADV_RESET; // RULE6
		end else if (mreq.wr) begin
			if (mreq.addr == `EPA_R_BC) begin
				bc_q <= mreq.wdata & `EPA_BC_WMASK;
			end
			if (mreq.addr == `EPA_R_ADV) begin
				adv_q <= mreq.wdata & `EPA_ADV_WMASK | 16'(`EPA_SEL_8023); // RULE6 RULE8 RULE13
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			fc_q <= 3'h0;
		end else if (wr_go && wsel == `EPA_I_FC) begin
			fc_q <= wv[2:0]; // RULE16
		end
	end

	always_comb begin
		case (mreq.addr) // RULE1
		`EPA_R_BC:  mrd = bc_q | 16'(bc_rst_q) << `EPA_BC_RST;
		`EPA_R_BS:  mrd = `EPA_BS_FIXED | 16'(anc_q) << `EPA_BS_ANC;
		`EPA_R_ID1: mrd = `EPA_ID1_VAL;
		`EPA_R_ID2: mrd = `EPA_ID2_VAL;
		`EPA_R_ADV: mrd = adv_q;
		`EPA_R_LP:  mrd = lp_q;
		`EPA_R_EXP: mrd = {14'h0000, page_q, lpa_q};
		default:    mrd = 16'hFFFF;
		endcase
	end

	epa_mdio_slave u_mdio (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.mdc_in      (mdc_in),
		.mdio_in     (mdio_in),
		.mdio_out    (mdio_out),
		.mdio_oe_out (mdio_oe_out),
		.rdata_in    (mrd),
		.req_out     (mreq)
	);

	// ------------------------------------------------------------
	// Emulated auto-negotiation
	// ------------------------------------------------------------
	epa_resolve u_res (
		.adv_in     (adv_q[8:5]),
		.common_out (r_common),
		.speed_out  (r_spd),
		.full_out   (r_full),
		.tech_out   (r_tech)
	);

	assign an_take = an_st == AN_IDLE && bc_q[`EPA_BC_ANEN] && !busy; // RULE2
	assign an_set  = rst_end | (mbc & mreq.wdata[`EPA_BC_RESTART]); // RULE3

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			an_req_q <= 1'b1; // RULE3
		end else begin
			an_req_q <= an_set | (an_req_q & ~an_take);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || busy) begin
			an_st      <= AN_IDLE;
			anc_q      <= 1'b0;
			page_q     <= 1'b0;
			lpa_q      <= 1'b0;
			lp_q       <= 16'h0000;
			res_spd_q  <= 1'b1;
			res_full_q <= 1'b1;
			res_tx_q   <= 1'b0;
			res_rx_q   <= 1'b0;
		end else begin
			case (an_st)
			AN_IDLE: begin
				if (an_take && an_req_q) begin
					anc_q  <= 1'b0;
					page_q <= 1'b0;
					an_st  <= AN_CPLT;
				end
			end
			AN_CPLT: begin
				anc_q <= 1'b1; // RULE4
				an_st <= AN_PAGE;
			end
			AN_PAGE: begin
				page_q <= 1'b1; // RULE4
				an_st  <= AN_LATCH;
			end
			AN_LATCH: begin
				res_spd_q  <= r_spd; // RULE4 RULE5 RULE7
				res_full_q <= r_full;
				lpa_q      <= r_common; // RULE9 RULE10
				lp_q       <= {4'h0, adv_q[11:10], 1'b0, r_tech, `EPA_SEL_8023}; // RULE8 RULE14
				res_tx_q   <= adv_q[10] | adv_q[11]; // RULE14
				res_rx_q   <= adv_q[10];
				an_st      <= AN_IDLE;
			end
			default: begin
				an_st <= AN_IDLE;
			end
			endcase
		end
	end

	a_an_gate: assert property (an_st == AN_IDLE ##1 an_st == AN_CPLT |-> $past(bc_q[`EPA_BC_ANEN])) // RULE2
		else $error("negotiation started while disabled");
	a_an_order: assert property (an_st == AN_CPLT |=> anc_q && !page_q ##1 anc_q && page_q) // RULE4
		else $error("negotiation steps out of order");
	a_best_mode: assert property (an_st == AN_LATCH && adv_q[8] // RULE5
		|=> res_spd_q && res_full_q && lpa_q)
		else $error("100 full not chosen when common");
	a_pd_fallback: assert property (an_st == AN_LATCH && adv_q[8:5] == 4'h0
		|=> !lpa_q && res_spd_q && !res_full_q && lp_q[8:5] == `EPA_TECH_PD) // RULE10
		else $error("parallel detect result wrong");
	a_result_hold: assert property (an_st == AN_IDLE && $past(an_st) == AN_IDLE && !busy
		|-> $stable(res_spd_q) && $stable(res_full_q)) // RULE7
		else $error("result changed outside negotiation");
	a_pause_mirror: assert property (an_st == AN_LATCH |=> lp_q[11:10] == $past(adv_q[11:10])) // RULE14
		else $error("partner pause does not mirror advertisement");

	// ------------------------------------------------------------
	// Host-side port settings
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			host_link_out <= '0;
		end else begin
			host_link_out.speed100 <= bc_q[`EPA_BC_ANEN] ? res_spd_q : bc_q[`EPA_BC_SPD]; // RULE11 RULE20
			host_link_out.full     <= bc_q[`EPA_BC_ANEN] ? res_full_q : bc_q[`EPA_BC_DUP]; // RULE11
			if (!bc_q[`EPA_BC_ANEN] || fc_q[`EPA_FC_SEL]) begin
				host_link_out.tx_pause <= fc_q[`EPA_FC_TX]; // RULE15
				host_link_out.rx_pause <= fc_q[`EPA_FC_RX];
			end else begin
				host_link_out.tx_pause <= res_tx_q; // RULE20
				host_link_out.rx_pause <= res_rx_q;
			end
		end
	end

	a_forced_mode: assert property (!bc_q[`EPA_BC_ANEN]
		|=> host_link_out.speed100 == $past(bc_q[`EPA_BC_SPD])
		&& host_link_out.full == $past(bc_q[`EPA_BC_DUP])) // RULE11
		else $error("forced speed or duplex not driven");
	a_manual_fc: assert property (fc_q[`EPA_FC_SEL] // RULE15
		|=> host_link_out.tx_pause == $past(fc_q[`EPA_FC_TX]))
		else $error("manual flow control not applied");

	c_an_success: cover property (an_st == AN_LATCH && r_common);
	c_an_pd: cover property (an_st == AN_LATCH && !r_common);
	c_long_reset: cover property ($fell(rc_phy_q));
	c_mdio_write: cover property (mreq.wr && mreq.addr == `EPA_R_ADV);
endmodule : epa_top

/* File: verification/emulated_phy_autoneg_tb.sv */
// Purpose: Self-checking bench for the emulated PHY.
// Assumes: 10 MHz clock; xorshift stimulus seeded with 5.
// Notes:   Management frames come from the host model.
`include "epa_defs.svh"
module emulated_phy_autoneg_tb import epa_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst_n, hw_n, awv, wv, bready, arv, rready, common;
	logic        awrdy, wrdy, bv, arrdy, rv, mdc, mdio, dout, doe;
	logic [1:0]  bresp, rresp, rsp;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, r32, seed, r, m;
	logic [15:0] md, adv;
	logic [3:0]  msk;
	epa_link_t   link, prev, expl;
	int          n_errors, num_checks;
	epa_mdio_host u_host (.clk_sys_in(clk_sys), .dev_out_in(dout), .dev_oe_in(doe),
		.mdc_out(mdc), .mdio_out(mdio));
	epa_top u_dut (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .hardware_reset_pin_n_in(hw_n),
		.mdc_in(mdc), .mdio_in(mdio), .mdio_out(dout), .mdio_oe_out(doe),
		.s_awaddr_in(awaddr), .s_awvalid_in(awv), .s_awready_out(awrdy), .s_wdata_in(wdata),
		.s_wstrb_in(4'hF), .s_wvalid_in(wv), .s_wready_out(wrdy), .s_bresp_out(bresp),
		.s_bvalid_out(bv), .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arv),
		.s_arready_out(arrdy), .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rv),
		.s_rready_in(rready), .host_link_out(link));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (90000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Highest common mode, parallel detect falls to 100 half
	function automatic epa_link_t exp_link(input logic [15:0] a);
		epa_link_t l;
		l.speed100 = a[8] | a[7] | ~|a[8:5];
		l.full     = a[8] | (~a[7] & a[6]);
		l.tx_pause = a[10] | a[11];
		l.rx_pause = a[10];
		return l;
	endfunction : exp_link
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic mf(input logic wr, input logic [4:0] ra, input logic [15:0] wd);
		u_host.frame(wr, ra, wd, md);
	endtask : mf
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata  <= d;
		awv    <= 1'b1;
		wv     <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (awv && awrdy) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (bv && bready) begin
				rsp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axw
	task automatic axr(input logic [7:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arv    <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (arv && arrdy) arv <= 1'b0;
			if (rv && rready) begin
				r32 = rdata;
				rsp = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axr
	initial begin
		{rst_n, awv, wv, bready, arv, rready} = 6'h00;
		hw_n   = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata  = 32'h0;
		seed   = 32'h5;
		tick(2);
		rst_n <= 1'b1;
		tick(20);
		chk("link", link, 4'hF);
		mf(1'b0, `EPA_R_ADV, 16'h0);
		chk("adv", md, 16'h0DE1);
		mf(1'b0, `EPA_R_BS, 16'h0);
		chk("complete", md[5], 1'b1);
		mf(1'b0, 5'h07, 16'h0);
		chk("absent", md, 16'hFFFF);
		mf(1'b0, `EPA_R_ID1, 16'h0);
		chk("id", md, `EPA_ID1_VAL);
		axw(8'h20, 32'h1);
		chk("bresp", rsp, 2'h2);
		axr(8'h20);
		chk("rresp", rsp, 2'h2);
		$display("done: defaults");
		for (int i = 0; i < 8; i++) begin
			r      = xs();
			adv    = {4'h0, r[11:10], 1'b0, (i == 0) ? 4'h0 : r[8:5], 5'h01};
			common = |adv[8:5];
			msk    = common ? 4'hF : 4'hC;
			expl   = exp_link(adv);
			prev   = link;
			mf(1'b1, `EPA_R_ADV, adv);
			tick(20);
			chk("held", link, prev);
			mf(1'b1, `EPA_R_BC, 16'h1200);
			tick(20);
			chk("result", link & msk, expl & msk);
			axr(`EPA_A_STATUS);
			chk("status", r32[5:4], {1'b1, common});
			mf(1'b0, `EPA_R_EXP, 16'h0);
			chk("expansion", md[1:0], {1'b1, common});
			mf(1'b0, `EPA_R_LP, 16'h0);
			chk("partner", md[9:5], common ? 5'h0F : 5'h04);
			if (common) chk("mirror", md[11:10], adv[11:10]);
		end
		$display("done: negotiation");
		for (int k = 0; k < 4; k++) begin
			r = xs();
			axw(`EPA_A_FC, {29'h0, r[2:1], k[1]});
			mf(1'b1, `EPA_R_BC, {2'h0, k[1], 4'h0, k[0], 8'h00});
			tick(20);
			chk("forced", link, {k[1], k[0], r[1], r[2]});
			axr(`EPA_A_FC);
			chk("flow", r32[5:0], {k[0], r[2], r[1], r[2], r[1], k[1]});
			mf(1'b0, `EPA_R_ADV, 16'h0);
			chk("adv pause", md[11:10], adv[11:10]);
		end
		$display("done: forced");
		// Manual select overrides negotiated pause only
		axw(`EPA_A_FC, 32'h5);
		mf(1'b1, `EPA_R_BC, 16'h1200);
		tick(20);
		chk("manual", link, {expl.speed100, expl.full, 2'h1});
		axw(`EPA_A_FC, 32'h0);
		$display("done: manual");
		for (int k = 0; k < 5; k++) begin
			mf(1'b1, `EPA_R_ADV, 16'h0021);
			mf(1'b1, `EPA_R_BC, 16'h1200);
			tick(20);
			chk("slow", link, 4'h0);
			case (k)
				0: axw(`EPA_A_RSTCTL, 32'h8);
				1: axw(`EPA_A_PMT, 32'h400);
				2: mf(1'b1, `EPA_R_BC, 16'h9000);
				3: axw(`EPA_A_RELOAD, 32'h1);
				default: hw_n <= 1'b0;
			endcase
			tick(5);
			hw_n <= 1'b1;
			if (k < 2) begin
				m = k ? 32'h400 : 32'h8;
				tick(1000);
				axr(k ? `EPA_A_PMT : `EPA_A_RSTCTL);
				chk("busy", r32 & m, m);
				tick(30);
				axr(k ? `EPA_A_PMT : `EPA_A_RSTCTL);
				chk("cleared", r32 & m, 32'h0);
			end
			tick(20);
			chk("restart", link, 4'hF);
			mf(1'b0, `EPA_R_BC, 16'h0);
			chk("control", md, 16'h3100);
		end
		$display("done: resets");
		test_done();
	end
endmodule : emulated_phy_autoneg_tb

/* File: verification/epa_mdio_host.sv */
// Purpose: Host MAC management master model.
// Assumes: Wire pulled up; 5 clocks per MDC phase.
// Notes:   Read data sampled just before each MDC rise.
module epa_mdio_host (
	// Bench clock
	input  wire logic clk_sys_in,
	// Device drive
	input  wire logic dev_out_in,
	input  wire logic dev_oe_in,
	// Pins
	output logic      mdc_out,
	output logic      mdio_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv_q = 1'b1;
	initial mdc_out = 1'b0;
	// Released wire reads one through the pull-up
	assign mdio_out = dev_oe_in ? dev_out_in : drv_q;
	task automatic frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'h1, ~wr, wr, 5'h00, ra, wr ? {2'h2, wd} : 18'h3FFFF};
		for (int i = 63; i >= 0; i--) begin
			@(posedge clk_sys_in);
			mdc_out <= 1'b0;
			drv_q   <= f[i];
			repeat (5) @(posedge clk_sys_in);
			rd = {rd[14:0], mdio_out};
			mdc_out <= 1'b1;
			repeat (4) @(posedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		drv_q <= 1'b1;
	endtask : frame
endmodule : epa_mdio_host
